//--- adc_mode_field_decode.v
// apb-reached operating control register and decode of its lower fields
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "opctl_map.vh"

module adc_mode_field_decode (
  input wire ref_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg sharedInputPortPinHiOut,
  output reg sharedInputPortPinHiOe_n,
  output reg sharedInputPortPinLoOut,
  output reg sharedInputPortPinLoOe_n,
  output reg resultWordLengthSelect,
  output reg [4:0] resultWordBits,
  output reg referenceScaleSelect,
  output reg [7:0] spanSelect,
  output reg unipolarSelect,
  output reg breakDetectCurrentEnable,
  output reg [2:0] positiveInputSel,
  output reg [2:0] negativeInputSel,
  output reg differentialSelect,
  output reg testModeSelect,
  output reg [1:0] calibrationPairSel
);
  // the register itself, the only store of field values
  reg [15:0] operatingControl;
  wire [2:0] inputSpanCode;
  wire [2:0] inputPairCode;
  wire [7:0] decSpan;
  wire decUnipolar;
  wire [1:0] decCal;
  wire [2:0] decPos;
  wire [2:0] decNeg;
  wire decDiff;
  wire decTest;
  wire accessPhase;
  wire writeOk;
  reg [31:0] next_prdata;
  reg next_slverr;
  // reset view of the decoded fields, so output reset values cannot drift from the register reset
  wire [15:0] resetWord;
  wire [7:0] rstSpan;
  wire rstUnipolar;
  wire [1:0] rstCal;
  wire [2:0] rstPos;
  wire [2:0] rstNeg;
  wire rstDiff;
  wire rstTest;
  assign resetWord = `OPCTL_RESET;

  assign inputSpanCode = operatingControl[`F_SPAN_HI:`F_SPAN_LO];
  assign inputPairCode = operatingControl[`F_PAIR_HI:`F_PAIR_LO];

  // known address check, used by both read and write paths
  function mapped;
    input [11:0] addr;
    begin
      mapped = (addr == `ADDR_OPCTL) || (addr == `ADDR_STATUS) || (addr == `ADDR_SELECT);
    end
  endfunction

  // pin level: a disabled pin shows 0, so nothing stale appears when its driver turns back on
  function pinLevel;
    input enable;
    input portBit;
    begin
      pinLevel = enable & portBit;
    end
  endfunction

  // active-low driver enable, low while the pin is driven
  function pinOeN;
    input enable;
    begin
      pinOeN = ~enable;
    end
  endfunction

  // serial clocks per result word for a given word length bit
  function [4:0] wordBitsFor;
    input wordLong;
    begin
      wordBitsFor = wordLong ? `WORD_BITS_LONG : `WORD_BITS_SHORT;
    end
  endfunction

  span_pair_decode decoder (
    .inputSpanCode(inputSpanCode),
    .inputPairCode(inputPairCode),
    .polarity(operatingControl[`F_POLARITY]),
    .spanOneHot(decSpan),
    .unipolarSpan(decUnipolar),
    .calPair(decCal),
    .posInput(decPos),
    .negInput(decNeg),
    .diffMode(decDiff),
    .testMode(decTest)
  );

  // second decoder on the constant reset codes; it folds to constants
  // and keeps one source of truth for what each code means
  span_pair_decode resetDecoder (
    .inputSpanCode(resetWord[`F_SPAN_HI:`F_SPAN_LO]),
    .inputPairCode(resetWord[`F_PAIR_HI:`F_PAIR_LO]),
    .polarity(resetWord[`F_POLARITY]),
    .spanOneHot(rstSpan),
    .unipolarSpan(rstUnipolar),
    .calPair(rstCal),
    .posInput(rstPos),
    .negInput(rstNeg),
    .diffMode(rstDiff),
    .testMode(rstTest)
  );

  // slave answers in the second access cycle; pready is a flop so it rises one edge after penable
  assign accessPhase = psel & penable & ~pready;
  assign writeOk = accessPhase & pwrite & (paddr == `ADDR_OPCTL);

  // read mux; status and select words mirror the decoded selections for software
  always @* begin
    next_prdata = 32'h00000000;
    next_slverr = ~mapped(paddr);
    case (paddr)
      `ADDR_OPCTL: begin
        // the control word sits in the low half, upper half reads zero
        next_prdata = {16'h0000, operatingControl};
      end
      `ADDR_STATUS: begin
        // span one-hot in 15:8, test flag 6, calibration pair 5:4, positive input 2:0
        next_prdata = {16'h0000, decSpan, 1'b0, decTest, decCal, 1'b0, decPos};
      end
      `ADDR_SELECT: begin
        // differential 6, unipolar 5, word length in serial clocks 4:0
        next_prdata = {24'h000000, 1'b0, decDiff, decUnipolar, resultWordBits};
      end
      default: begin
        next_prdata = 32'h00000000;
      end
    endcase
  end

  // handshake: one pready pulse per transfer; the ~pready term in accessPhase
  // keeps the cycle in which pready is high from being served again; a master holding penable past it is served twice
  always @(posedge ref_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= accessPhase;
      pslverr <= accessPhase & next_slverr;
    end
  end

  // read data is captured on the access edge and held until the next read
  always @(posedge ref_clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (accessPhase & ~pwrite) begin
      prdata <= next_prdata;
    end
  end

  // register write: only the access edge commits, so fields never change mid-transfer
  // writes to the read-only words or to holes are dropped without touching the register
  always @(posedge ref_clk) begin
    if (rst) begin
      operatingControl <= `OPCTL_RESET;
    end else if (writeOk) begin
      // byte lanes are independent; a lane left out keeps its old fields
      if (pstrb[0]) begin
        operatingControl[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        operatingControl[15:8] <= pwdata[15:8];
      end
    end
  end

  // outputs follow the committed register one edge later, all from flops;
  // the extra edge costs a cycle but keeps every output glitch free

  // hi pin driver enable follows the pin enable bit
  always @(posedge ref_clk) begin
    if (rst) begin
      sharedInputPortPinHiOe_n <= pinOeN(resetWord[`F_PIN_EN]);
    end else begin
      sharedInputPortPinHiOe_n <= pinOeN(operatingControl[`F_PIN_EN]);
    end
  end

  // lo pin driver enable follows the same bit, so both pins switch together
  always @(posedge ref_clk) begin
    if (rst) begin
      sharedInputPortPinLoOe_n <= pinOeN(resetWord[`F_PIN_EN]);
    end else begin
      sharedInputPortPinLoOe_n <= pinOeN(operatingControl[`F_PIN_EN]);
    end
  end

  // hi pin level; held because only a write changes the register behind it
  always @(posedge ref_clk) begin
    if (rst) begin
      sharedInputPortPinHiOut <= pinLevel(resetWord[`F_PIN_EN], resetWord[`F_PORT_HI]);
    end else begin
      sharedInputPortPinHiOut <= pinLevel(operatingControl[`F_PIN_EN], operatingControl[`F_PORT_HI]);
    end
  end

  // lo pin level, same holding behaviour as the hi pin
  always @(posedge ref_clk) begin
    if (rst) begin
      sharedInputPortPinLoOut <= pinLevel(resetWord[`F_PIN_EN], resetWord[`F_PORT_LO]);
    end else begin
      sharedInputPortPinLoOut <= pinLevel(operatingControl[`F_PIN_EN], operatingControl[`F_PORT_LO]);
    end
  end

  // word length bit as a level for the result register
  always @(posedge ref_clk) begin
    if (rst) begin
      resultWordLengthSelect <= resetWord[`F_WORD_LEN];
    end else begin
      resultWordLengthSelect <= operatingControl[`F_WORD_LEN];
    end
  end

  // serial engine counts these clocks before ready returns;
  // a change mid-read only takes effect on the next read
  always @(posedge ref_clk) begin
    if (rst) begin
      resultWordBits <= wordBitsFor(resetWord[`F_WORD_LEN]);
    end else begin
      resultWordBits <= wordBitsFor(operatingControl[`F_WORD_LEN]);
    end
  end

  // reference scale is only passed on; the host must match it to the fitted reference
  always @(posedge ref_clk) begin
    if (rst) begin
      referenceScaleSelect <= resetWord[`F_REF_SCALE];
    end else begin
      referenceScaleSelect <= operatingControl[`F_REF_SCALE];
    end
  end

  // one-hot span, codes 000 and 001 share the smallest span
  always @(posedge ref_clk) begin
    if (rst) begin
      spanSelect <= rstSpan;
    end else begin
      spanSelect <= decSpan;
    end
  end

  // span starts at zero when set, symmetric when clear
  always @(posedge ref_clk) begin
    if (rst) begin
      unipolarSelect <= rstUnipolar;
    end else begin
      unipolarSelect <= decUnipolar;
    end
  end

  // break-detect currents; left on they add an offset, so software clears them after a check
  always @(posedge ref_clk) begin
    if (rst) begin
      breakDetectCurrentEnable <= resetWord[`F_BREAK];
    end else begin
      breakDetectCurrentEnable <= operatingControl[`F_BREAK];
    end
  end

  // positive input number, 1..6
  always @(posedge ref_clk) begin
    if (rst) begin
      positiveInputSel <= rstPos;
    end else begin
      positiveInputSel <= decPos;
    end
  end

  // negative input number; the common return input for the single-ended codes
  always @(posedge ref_clk) begin
    if (rst) begin
      negativeInputSel <= rstNeg;
    end else begin
      negativeInputSel <= decNeg;
    end
  end

  // fully differential pair flag
  always @(posedge ref_clk) begin
    if (rst) begin
      differentialSelect <= rstDiff;
    end else begin
      differentialSelect <= decDiff;
    end
  end

  // shorted test input; only meaningful while the return input sits in common-mode range
  always @(posedge ref_clk) begin
    if (rst) begin
      testModeSelect <= rstTest;
    end else begin
      testModeSelect <= decTest;
    end
  end

  // calibration coefficient pair shared by conversion and coefficient access
  always @(posedge ref_clk) begin
    if (rst) begin
      calibrationPairSel <= rstCal;
    end else begin
      calibrationPairSel <= decCal;
    end
  end
endmodule // adc_mode_field_decode
`default_nettype wire

//--- adc_mode_field_decode_sva.sv
// assertions on the mode field decoder ports
`timescale 1ns/1ps
`default_nettype none
module adc_mode_field_decode_sva (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic sharedInputPortPinHiOut,
  input wire logic sharedInputPortPinHiOe_n,
  input wire logic sharedInputPortPinLoOut,
  input wire logic sharedInputPortPinLoOe_n,
  input wire logic resultWordLengthSelect,
  input wire logic breakDetectCurrentEnable,
  input wire logic testModeSelect,
  input wire logic referenceScaleSelect,
  input wire logic unipolarSelect,
  input wire logic differentialSelect,
  input wire logic [4:0] resultWordBits,
  input wire logic [7:0] spanSelect,
  input wire logic [2:0] positiveInputSel,
  input wire logic [2:0] negativeInputSel,
  input wire logic [1:0] calibrationPairSel
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // a completed full write of the control word; wd holds its data one edge on
  wire wr = psel && penable && pready && pwrite && paddr == 12'h000 && pstrb[1:0] == 2'b11;
  logic [31:0] wd;
  always @(posedge ref_clk) wd <= pwdata;
  a_pin_drive: assert property (wr |=> sharedInputPortPinHiOut == (wd[10] & wd[11])
    && sharedInputPortPinLoOut == (wd[9] & wd[11]) && sharedInputPortPinLoOe_n == !wd[11]) else $error("pin drive");
  a_pin_hold: assert property (!wr |=> $stable({sharedInputPortPinHiOut, sharedInputPortPinLoOut}))
    else $error("pin moved");
  a_word_len: assert property (wr |=> resultWordBits == (wd[8] ? 5'h18 : 5'h10) && resultWordLengthSelect == wd[8])
    else $error("word length");
  a_span_code: assert property (wr |=> spanSelect == 8'h01 << (wd[6:4] == 3'h0 ? 3'h1 : wd[6:4]))
    else $error("span");
  a_break_level: assert property (wr |=> breakDetectCurrentEnable == wd[3]) else $error("break");
  a_cal_pair: assert property (wr |=> calibrationPairSel == (wd[1] ? 2'h2 : {1'b0, wd[0]})) else $error("cal");
  a_test_short: assert property (wr |=> testModeSelect == (wd[2:0] == 3'h7)) else $error("test");
  a_input_pair: assert property (wr |=> differentialSelect == (wd[2] && wd[1:0] != 2'h3)
    && positiveInputSel == (wd[2] ? (wd[1:0] == 2'h3 ? 3'h6 : {wd[1:0], 1'b1}) : wd[2:0] + 3'h1)
    && negativeInputSel == ((wd[2] && !wd[1]) ? {wd[1:0], 1'b0} + 3'h2 : 3'h6)) else $error("input pair");
  a_unipolar_level: assert property (wr |=> unipolarSelect == wd[12] && referenceScaleSelect == wd[7])
    else $error("unipolar");
  a_hi_enable: assert property (wr |=> sharedInputPortPinHiOe_n == !wd[11]) else $error("hi enable");
  a_reset_default: assert property ($fell(rst) |-> spanSelect == 8'h80 && positiveInputSel == 3'h1
    && negativeInputSel == 3'h2 && calibrationPairSel == 2'h0) else $error("reset");
endmodule // adc_mode_field_decode_sva
bind adc_mode_field_decode adc_mode_field_decode_sva i_sva (.*);
`default_nettype wire

//--- adc_mode_field_decode_tb_top.sv
// self-checking bench for the mode field decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin nFail++; $display("wrong value %s exp %h got %h", n, e, s); end end
module adc_mode_field_decode_tb_top;
  logic ref_clk = 0, rst = 1, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [15:0] lfsr = 16'h0013, d;
  logic [32:0] q[$], e;
  int nFail = 0, checked = 0, cyc = 0;
  always #10 ref_clk = ~ref_clk;
  function automatic logic [15:0] lfsrNext(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  apb_host_model i_host (.ref_clk(ref_clk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
  adc_mode_field_decode i_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sharedInputPortPinHiOut(), .sharedInputPortPinHiOe_n(), .sharedInputPortPinLoOut(),
    .sharedInputPortPinLoOe_n(), .resultWordLengthSelect(), .resultWordBits(), .referenceScaleSelect(),
    .spanSelect(), .unipolarSelect(), .breakDetectCurrentEnable(), .positiveInputSel(),
    .negativeInputSel(), .differentialSelect(), .testModeSelect(), .calibrationPairSel());
  task tally_and_finish;
    if (nFail == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task rd(input logic [11:0] a, input logic [32:0] x);
    q.push_back(x);
    i_host.xfer(0, a, 0);
  endtask
  // watcher: every read answer meets the oldest note; a hang is cut off by the cycle ceiling
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      nFail++;
      tally_and_finish;
    end else if (psel && penable && pready && !pwrite) begin
      e = q.pop_front();
      `CHK("read", e, {pslverr, prdata})
    end
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 0;
    rd(12'h000, 33'h74);
    rd(12'h004, 33'h8001);
    rd(12'h00c, 33'h100000000);
    for (int c = 0; c < 8; c++) begin
      lfsr = lfsrNext(lfsr);
      d = (lfsr & 16'h1f08) | 16'h0080 | {c[2:0], 4'h0} | c[2:0]; // a 5 V reference is fitted
      i_host.xfer(1, 12'h000, {16'h0, d});
      i_host.xfer(1, 12'h004, 32'h0);
      rd(12'h000, {17'h0, d});
      rd(12'h004, {17'h0, 8'h01 << (c == 0 ? 1 : c), 1'b0, c == 7, c[1] ? 2'h2 : {1'b0, c[0]}, 1'b0,
        c < 4 ? c[2:0] + 3'h1 : c == 7 ? 3'h6 : {c[1:0], 1'b1}});
      rd(12'h008, {26'h0, c[2] && c != 7, d[12], d[8] ? 5'h18 : 5'h10});
    end
    @(posedge ref_clk);
    tally_and_finish;
  end
endmodule // adc_mode_field_decode_tb_top
`default_nettype wire

//--- apb_host_model.sv
// apb host standing in for the controller that programs the block
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
  input wire logic ref_clk,
  input wire logic pready,
  output var logic psel, penable, pwrite,
  output var logic [11:0] paddr,
  output var logic [31:0] pwdata,
  output var logic [3:0] pstrb
);
  initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  // setup, then access held until pready; released data toggles so it never lingers
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, {4{w}}};
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    {psel, penable, pwdata} <= {2'b00, ~d};
  endtask
endmodule // apb_host_model
`default_nettype wire

//--- opctl_map.vh
// register offsets, field positions, reset values and timing counts for the mode field decoder
`ifndef OPCTL_MAP_VH
`define OPCTL_MAP_VH
// byte addresses on the apb bus
`define ADDR_OPCTL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_SELECT 12'h008
`define ADDR_BITS 12
// field positions inside operating_control
`define F_POLARITY 12
`define F_PIN_EN 11
`define F_PORT_HI 10
`define F_PORT_LO 9
`define F_WORD_LEN 8
`define F_REF_SCALE 7
`define F_SPAN_HI 6
`define F_SPAN_LO 4
`define F_BREAK 3
`define F_PAIR_HI 2
`define F_PAIR_LO 0
// reset value: span code 111, pair code 100, all else zero
`define OPCTL_RESET 16'h0074
// serial read lengths in serial clock cycles
`define WORD_BITS_SHORT 5'h10
`define WORD_BITS_LONG 5'h18
`endif

//--- span_pair_decode.v
// combinational decode of span code and input pair code
`timescale 1ns/1ps
`default_nettype none
module span_pair_decode (
  input wire [2:0] inputSpanCode,
  input wire [2:0] inputPairCode,
  input wire polarity,
  output reg [7:0] spanOneHot,
  output reg unipolarSpan,
  output reg [1:0] calPair,
  output reg [2:0] posInput,
  output reg [2:0] negInput,
  output reg diffMode,
  output reg testMode
);
  // codes 000 and 001 both give the 20 mV span, each code above doubles it
  always @* begin
    spanOneHot = 8'h00;
    if (inputSpanCode == 3'h0)
      spanOneHot[1] = 1'b1;
    else
      spanOneHot[inputSpanCode] = 1'b1;
    unipolarSpan = polarity;
  end

  // input pair and calibration pair from the channel code, inputs numbered 1..6
  always @* begin
    // code 111 is the shorted test input, not a differential pair
    diffMode = inputPairCode[2] & ~(&inputPairCode);
    testMode = 1'b0;
    case (inputPairCode)
      3'h0: begin posInput = 3'h1; negInput = 3'h6; calPair = 2'h0; end
      3'h1: begin posInput = 3'h2; negInput = 3'h6; calPair = 2'h1; end
      3'h2: begin posInput = 3'h3; negInput = 3'h6; calPair = 2'h2; end
      3'h3: begin posInput = 3'h4; negInput = 3'h6; calPair = 2'h2; end
      3'h4: begin posInput = 3'h1; negInput = 3'h2; calPair = 2'h0; end
      3'h5: begin posInput = 3'h3; negInput = 3'h4; calPair = 2'h1; end
      3'h6: begin posInput = 3'h5; negInput = 3'h6; calPair = 2'h2; end
      default: begin posInput = 3'h6; negInput = 3'h6; calPair = 2'h2; testMode = 1'b1; end
    endcase
  end
endmodule // span_pair_decode
`default_nettype wire
